// ===== cpt_params.svh
// constants for the character pulse test source: offsets, fields, resets, timing
// assumes a 50 MHz sys_clk; included by cpt_pkg and the design modules
`ifndef CPT_PARAMS_SVH
`define CPT_PARAMS_SVH

// =====================================================================
// register offsets (byte addresses)
`define CPT_ADDR_CTRL 8'h00
`define CPT_ADDR_CODE 8'h04
`define CPT_ADDR_WIDTH 8'h08
`define CPT_ADDR_STATUS 8'h0c

// =====================================================================
// control register fields
`define CPT_CTRL_MODE_LSB 0
`define CPT_CTRL_MODE_MSB 1
`define CPT_CTRL_RX_BIT 2
`define CPT_CTRL_SEL_BIT 3

// =====================================================================
// reset values
`define CPT_CODE_RST 7'h7f
`define CPT_WIDTH_RST 8'h32

// =====================================================================
// timing
`define CPT_CLK_KHZ 50000
`define CPT_INTERVAL_MS 9
`define CPT_INTERVAL_CYC (`CPT_INTERVAL_MS * `CPT_CLK_KHZ)
`define CPT_DEBOUNCE_MS 5
`define CPT_DEBOUNCE_CYC (`CPT_DEBOUNCE_MS * `CPT_CLK_KHZ)
`define CPT_PROBE_FILTER_CYC 3

`endif

// ===== cpt_pkg.sv
// types shared by the character pulse test source modules
// assumes cpt_params.svh sits in the same folder
`include "cpt_params.svh"

package cpt_pkg;

  // =====================================================================
  // strobe modes; code 2'b11 decodes as off
  typedef enum logic [1:0] {
    CPT_MODE_OFF = 2'b00,
    CPT_MODE_REPEAT = 2'b01,
    CPT_MODE_MANUAL = 2'b10
  } cpt_mode_t;

  // =====================================================================
  // clocked flip-flop state
  typedef struct packed {
    logic q;
    logic q_n;
  } cpt_jk_t;

  // =====================================================================
  // top-level state
  typedef struct packed {
    cpt_mode_t mode;
    logic rx;
    logic sel;
    logic [6:0] code;
    logic [7:0] width;
    logic btn_s1;
    logic btn_s2;
    logic btn_db;
    logic btn_last;
    logic [19:0] db_cnt;
    logic prb_s1;
    logic prb_s2;
    logic prb_db;
    logic prb_last;
    logic [1:0] prb_cnt;
    logic [19:0] osc_cnt;
    logic gate_last;
    logic busy;
    logic [7:0] strb_cnt;
    logic strobe_mode_selector_n;
    logic auto_on_out;
    logic auto_on_oe;
    logic [6:0] code_out;
    logic [6:0] code_oe;
    logic meter_out;
    logic [31:0] rdata;
  } cpt_state_t;

endpackage : cpt_pkg

// ===== cpt_jk_ff.sv
// clocked flip-flop with direct set and direct clear, wired for j-k use
// assumes tick is a per-cycle enable from logic on sys_clk; a held tick acts every cycle
`timescale 1ns/1ps
`include "cpt_params.svh"

module cpt_jk_ff
  import cpt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic j,
  input wire logic k,
  input wire logic set_n,
  input wire logic clr_n,
  output logic q,
  output logic q_n
);

  cpt_jk_t st;
  cpt_jk_t next_st;

  // =====================================================================
  // next state
  always_comb
  begin
    next_st = st;
    if (clk_en)
    begin
      if (!set_n && !clr_n)
      begin
        // both direct inputs low drive both outputs high
        next_st.q = 1'b1;
        next_st.q_n = 1'b1;
      end
      else if (!set_n)
      begin
        next_st.q = 1'b1;
        next_st.q_n = 1'b0;
      end
      else if (!clr_n)
      begin
        next_st.q = 1'b0;
        next_st.q_n = 1'b1;
      end
      else if (tick)
      begin
        case ({j, k})
          2'b10: next_st.q = 1'b1;
          2'b01: next_st.q = 1'b0;
          2'b11: next_st.q = ~st.q;
          default: next_st.q = st.q;
        endcase
        next_st.q_n = ~next_st.q;
      end
      else
      begin
        // leaving the both-low override restores a true complement
        next_st.q_n = ~st.q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '{q: 1'b0, q_n: 1'b1};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q = st.q;
  assign q_n = st.q_n;

  // =====================================================================
  // checks
  both_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && !set_n && !clr_n |=> q && q_n)
    else $error("direct set and clear low did not drive both outputs high");

  jk_toggle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && set_n && clr_n && tick && j && k |=> q != $past(q))
    else $error("j-k toggle did not change state");

  jk_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && set_n && clr_n && tick && !j && !k |=> $stable(q))
    else $error("j-k hold changed state");

endmodule : cpt_jk_ff

// ===== cpt_source.sv
// character pulse test source: code lines, auto-on pull, character strobes, pulse detect
// assumes a 50 MHz sys_clk, asynchronous button and probe pins, and a simple
// register port on sys_clk; open-drain pins are resolved outside the design
`timescale 1ns/1ps
`include "cpt_params.svh"

// Operation
// - receive switch on pulls auto-on low
// - mark leaves line open, space drives low
// - seven independent parallel code lines
// - repeat mode strobes every 9 ms
// - gate flop toggles each oscillator tick
// - strobe rests high, pulses low
// - off mode holds gate set, no strobe
// - button press alone gives no strobe
// - strobe end re-inhibits the arm flop unless a release meets it
// - one strobe per press and release
// - pulse detect only in pulse selection
// - detect toggle flips once per probe pulse
// - idle meter shows stored toggle level
// - direct set and clear override clock
// - j-k hold, set, clear, toggle
module cpt_source
  import cpt_pkg::*;
#(
  parameter int INTERVAL_CYCLES = `CPT_INTERVAL_CYC,
  parameter int DEBOUNCE_CYCLES = `CPT_DEBOUNCE_CYC
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic single_step_button,
  input wire logic probe_in,
  output logic auto_on_out,
  output logic auto_on_oe,
  output logic [6:0] code_out,
  output logic [6:0] code_oe,
  output logic strobe_mode_selector_n,
  output logic meter_out
);

  // =====================================================================
  // helpers
  function automatic cpt_mode_t decode_mode(input logic [1:0] raw);
    case (raw)
      2'b01: decode_mode = CPT_MODE_REPEAT;
      2'b10: decode_mode = CPT_MODE_MANUAL;
      default: decode_mode = CPT_MODE_OFF;
    endcase
  endfunction : decode_mode

  function automatic logic [7:0] eff_width(input logic [7:0] w);
    // a zero width would hide the strobe, so it counts as one cycle
    eff_width = (w == 8'h00) ? 8'h01 : w;
  endfunction : eff_width

  localparam logic [19:0] HALF_LAST = 20'(INTERVAL_CYCLES / 2 - 1);
  localparam logic [19:0] DEB_LAST = 20'(DEBOUNCE_CYCLES - 1);
  localparam logic [1:0] PRB_LAST = 2'(`CPT_PROBE_FILTER_CYC - 1);

  cpt_state_t st;
  cpt_state_t next_st;

  logic gate_q;
  logic arm_q;
  logic pd_q;
  logic osc_tick;
  logic strb_start;
  logic strb_end;
  logic btn_rel;
  logic btn_press;
  logic probe_edge;
  logic gate_tick;
  logic gate_set_n;
  logic arm_tick;
  logic arm_clr_n;

  // =====================================================================
  // events from the current state
  always_comb
  begin
    osc_tick = clk_en && (st.mode == CPT_MODE_REPEAT) && (st.osc_cnt == HALF_LAST);
    strb_start = clk_en && st.gate_last && !gate_q;
    strb_end = clk_en && st.busy && (st.strb_cnt == 8'h01);
    btn_rel = clk_en && st.btn_last && !st.btn_db;
    btn_press = clk_en && !st.btn_last && st.btn_db;
    probe_edge = clk_en && st.sel && st.prb_db && !st.prb_last;
    // off holds the gate set; manual holds it set until armed
    gate_set_n = !((st.mode == CPT_MODE_OFF) ||
                   ((st.mode == CPT_MODE_MANUAL) && !arm_q));
    gate_tick = osc_tick || ((st.mode == CPT_MODE_MANUAL) && arm_q);
    // arm is clocked every cycle; j and k pick set, clear or hold
    arm_tick = clk_en;
    arm_clr_n = (st.mode == CPT_MODE_MANUAL);
  end

  // =====================================================================
  // storage flip-flops
  cpt_jk_ff u_gate (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .tick(gate_tick),
    .j(st.mode == CPT_MODE_REPEAT),
    .k(1'b1),
    .set_n(gate_set_n),
    .clr_n(1'b1),
    .q(gate_q),
    .q_n()
  );

  // a release that meets the strobe end wins, so that press is kept
  cpt_jk_ff u_arm (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .tick(arm_tick),
    .j(btn_rel),
    .k(strb_end && !btn_rel),
    .set_n(1'b1),
    .clr_n(arm_clr_n),
    .q(arm_q),
    .q_n()
  );

  cpt_jk_ff u_pd (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .tick(probe_edge),
    .j(1'b1),
    .k(1'b1),
    .set_n(1'b1),
    .clr_n(1'b1),
    .q(pd_q),
    .q_n()
  );

  // =====================================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.rdata = 32'h0000_0000;
    if (clk_en)
    begin
      // pin synchronisers; stage one feeds stage two only
      next_st.btn_s1 = single_step_button;
      next_st.btn_s2 = st.btn_s1;
      next_st.prb_s1 = probe_in;
      next_st.prb_s2 = st.prb_s1;
      next_st.btn_last = st.btn_db;
      next_st.prb_last = st.prb_db;
      next_st.gate_last = gate_q;

      // button debounce: the level must hold for the whole window
      if (st.btn_s2 != st.btn_db)
      begin
        if (st.db_cnt == DEB_LAST)
        begin
          next_st.btn_db = st.btn_s2;
          next_st.db_cnt = 20'h00000;
        end
        else
        begin
          next_st.db_cnt = st.db_cnt + 20'h00001;
        end
      end
      else
      begin
        next_st.db_cnt = 20'h00000;
      end

      // probe filter is short so fast pulses still reach the toggle
      if (st.prb_s2 != st.prb_db)
      begin
        if (st.prb_cnt == PRB_LAST)
        begin
          next_st.prb_db = st.prb_s2;
          next_st.prb_cnt = 2'h0;
        end
        else
        begin
          next_st.prb_cnt = st.prb_cnt + 2'h1;
        end
      end
      else
      begin
        next_st.prb_cnt = 2'h0;
      end

      // oscillator: one tick per half interval, gate falls every second tick
      if (st.mode != CPT_MODE_REPEAT || osc_tick)
      begin
        next_st.osc_cnt = 20'h00000;
      end
      else
      begin
        next_st.osc_cnt = st.osc_cnt + 20'h00001;
      end

      // strobe former
      if (strb_start)
      begin
        next_st.busy = 1'b1;
        next_st.strb_cnt = eff_width(st.width);
        next_st.strobe_mode_selector_n = 1'b0;
      end
      else if (strb_end)
      begin
        next_st.busy = 1'b0;
        next_st.strb_cnt = 8'h00;
        next_st.strobe_mode_selector_n = 1'b1;
      end
      else if (st.busy)
      begin
        next_st.strb_cnt = st.strb_cnt - 8'h01;
      end

      // pins
      next_st.auto_on_out = 1'b0;
      next_st.auto_on_oe = st.rx;
      next_st.code_out = 7'h00;
      next_st.code_oe = ~st.code;
      next_st.meter_out = st.sel ? pd_q : 1'b0;

      // register port
      if (wr_en)
      begin
        case (addr)
          `CPT_ADDR_CTRL:
          begin
            next_st.mode = decode_mode(wdata[`CPT_CTRL_MODE_MSB:`CPT_CTRL_MODE_LSB]);
            next_st.rx = wdata[`CPT_CTRL_RX_BIT];
            next_st.sel = wdata[`CPT_CTRL_SEL_BIT];
          end
          `CPT_ADDR_CODE: next_st.code = wdata[6:0];
          `CPT_ADDR_WIDTH: next_st.width = wdata[7:0];
          default: next_st.code = st.code;
        endcase
      end
      if (rd_en)
      begin
        case (addr)
          `CPT_ADDR_CTRL: next_st.rdata = {28'h0000000, st.sel, st.rx, st.mode};
          `CPT_ADDR_CODE: next_st.rdata = {25'h0000000, st.code};
          `CPT_ADDR_WIDTH: next_st.rdata = {24'h000000, st.width};
          `CPT_ADDR_STATUS: next_st.rdata = {28'h0000000, st.btn_db, arm_q, st.busy, pd_q};
          default: next_st.rdata = 32'h0000_0000;
        endcase
      end
    end
    else
    begin
      // frozen: read data holds its value until clk_en returns
      next_st.rdata = st.rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.mode <= CPT_MODE_OFF;
      st.code <= `CPT_CODE_RST;
      st.width <= `CPT_WIDTH_RST;
      st.strobe_mode_selector_n <= 1'b1;
      st.gate_last <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign auto_on_out = st.auto_on_out;
  assign auto_on_oe = st.auto_on_oe;
  assign code_out = st.code_out;
  assign code_oe = st.code_oe;
  assign strobe_mode_selector_n = st.strobe_mode_selector_n;
  assign meter_out = st.meter_out;

  // =====================================================================
  // checking helpers
  logic [19:0] gap_cnt;
  logic gap_valid;
  logic [7:0] low_cnt;
  logic [7:0] strb_w;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gap_cnt <= 20'h00000;
      gap_valid <= 1'b0;
      low_cnt <= 8'h00;
      strb_w <= 8'h00;
    end
    else if (clk_en)
    begin
      if (st.mode != CPT_MODE_REPEAT)
      begin
        gap_valid <= 1'b0;
        gap_cnt <= 20'h00000;
      end
      else if (strb_start)
      begin
        gap_valid <= 1'b1;
        gap_cnt <= 20'h00001;
      end
      else
      begin
        gap_cnt <= gap_cnt + 20'h00001;
      end
      low_cnt <= strobe_mode_selector_n ? 8'h00 : low_cnt + 8'h01;
      // width latched at start: a write during a strobe applies to the next one
      if (strb_start)
        strb_w <= eff_width(st.width);
    end
  end

  // =====================================================================
  // checks
  sequence s_release;
    clk_en && st.mode == CPT_MODE_MANUAL && btn_rel;
  endsequence

  sequence s_armed;
    arm_q ##1 !gate_q;
  endsequence

  rx_pull_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && st.rx |=> auto_on_oe && !auto_on_out)
    else $error("auto-on line not pulled low while receive is on");

  code_lines_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en |=> code_oe == ~$past(st.code) && code_out == 7'h00)
    else $error("code line drive does not match mark and space");

  repeat_gap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    strb_start && gap_valid && st.mode == CPT_MODE_REPEAT |->
      gap_cnt == 20'(INTERVAL_CYCLES / 2 * 2))
    else $error("repeat strobe interval wrong");

  gate_toggle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    osc_tick && gate_set_n |=> gate_q != $past(gate_q))
    else $error("gate flop did not toggle on oscillator tick");

  strobe_width_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && $rose(strobe_mode_selector_n) && $past(clk_en) |-> $past(low_cnt) + 8'h01 == strb_w)
    else $error("strobe low time differs from width register");

  off_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    st.mode == CPT_MODE_OFF && $past(st.mode) == CPT_MODE_OFF |-> !strb_start)
    else $error("strobe started in off mode");

  press_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    btn_press && st.mode == CPT_MODE_MANUAL && !arm_q |=> !strb_start && !arm_q)
    else $error("button press alone armed a strobe");

  release_strobe_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_release ##1 (clk_en && st.mode == CPT_MODE_MANUAL) |-> s_armed)
    else $error("release did not start a strobe");

  end_rearm_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    strb_end && !btn_rel && st.mode == CPT_MODE_MANUAL |=> !arm_q)
    else $error("arm flop not cleared at strobe end");

  pd_toggle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    probe_edge |=> pd_q != $past(pd_q))
    else $error("pulse detect toggle missed a probe pulse");

  meter_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && st.sel |=> meter_out == $past(pd_q))
    else $error("meter output does not follow detect toggle");

  meter_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && !st.sel |=> !meter_out)
    else $error("meter driven outside pulse selection");

endmodule : cpt_source

// ===== cpt_printer_model.sv
// printer side model: power supply auto-on input and character generator inputs
// assumes pulled-up open-drain lines, sampled on the source's sys_clk
`timescale 1ns/1ps

// =====================================================================
// far end of the test source
module cpt_printer_model
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic auto_on_out,
  input wire logic auto_on_oe,
  input wire logic [6:0] code_out,
  input wire logic [6:0] code_oe,
  input wire logic strobe_mode_selector_n,
  output int strobe_cnt,
  output int last_width,
  output int last_gap,
  output logic [6:0] last_code
);
  int cyc;
  int start;
  int wcnt;
  logic prev_n;
  logic hv_on;
  logic [6:0] lines;

  // an undriven line floats up to the pull-up level
  assign hv_on = auto_on_oe & !auto_on_out;
  assign lines = (code_out & code_oe) | ~code_oe;

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cyc <= 0;
      start <= 0;
      wcnt <= 0;
      prev_n <= 1'b1;
      strobe_cnt <= 0;
      last_width <= 0;
      last_gap <= 0;
      last_code <= 7'h00;
    end
    else
    begin
      cyc <= cyc + 1;
      prev_n <= strobe_mode_selector_n;
      // only a falling strobe with high voltage on prints a character
      if (prev_n && !strobe_mode_selector_n && hv_on)
      begin
        strobe_cnt <= strobe_cnt + 1;
        last_code <= lines;
        last_gap <= cyc - start;
        start <= cyc;
      end
      if (!strobe_mode_selector_n)
        wcnt <= wcnt + 1;
      else if (!prev_n)
      begin
        last_width <= wcnt;
        wcnt <= 0;
      end
    end
  end
endmodule : cpt_printer_model

// ===== tb_top.sv
// self-checking bench for the character pulse test source
// assumes cpt_pkg, cpt_source and cpt_printer_model are compiled before it
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))

module tb_top;
  localparam int IVL = 200;
  localparam int DBC = 4;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic btn = 1'b0;
  logic probe = 1'b0;
  logic [31:0] rdata;
  logic auto_on_out, auto_on_oe, strobe_mode_selector_n, meter_out;
  logic [6:0] code_out, code_oe, last_code;
  int strobe_cnt, last_width, last_gap;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 32'h0bbf;
  // reference copies of what the registers and the toggle should hold
  int m_code, m_width, m_pd, weff, c0, n;
  logic [31:0] d;
  logic [31:0] v;

  always #10 sys_clk = ~sys_clk;

  cpt_source #(.INTERVAL_CYCLES(IVL), .DEBOUNCE_CYCLES(DBC)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .single_step_button(btn), .probe_in(probe), .auto_on_out(auto_on_out), .auto_on_oe(auto_on_oe),
    .code_out(code_out), .code_oe(code_oe), .strobe_mode_selector_n(strobe_mode_selector_n), .meter_out(meter_out));

  cpt_printer_model i_printer (.sys_clk(sys_clk), .reset_n(reset_n), .auto_on_out(auto_on_out),
    .auto_on_oe(auto_on_oe), .code_out(code_out), .code_oe(code_oe), .strobe_mode_selector_n(strobe_mode_selector_n),
    .strobe_cnt(strobe_cnt), .last_width(last_width), .last_gap(last_gap), .last_code(last_code));

  // =====================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] val);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= val;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] val);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    val = rdata;
  endtask : rd

  // waits a bounded time for k more printed characters
  task automatic wait_strobes(input int k);
    c0 = strobe_cnt;
    for (int i = 0; i < k * 260 + 300 && strobe_cnt < c0 + k; i++)
      @(posedge sys_clk);
    #1;
    `CHK("strobe count", c0 + k, strobe_cnt);
  endtask : wait_strobes

  task automatic done(input string nm);
    $display("test %s ended, mismatches so far %0d", nm, error_cnt);
  endtask : done

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // =====================================================================
  // watchdog, a few times the expected run length
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    error_cnt++;
    summarize();
  end

  // =====================================================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    cyc(2);
    `CHK("strobe idle", 1, strobe_mode_selector_n);
    `CHK("code enables", 0, code_oe);
    `CHK("auto-on enable", 0, auto_on_oe);
    rd(8'h04, d);
    `CHK("code reset", 32'h7f, d);
    rd(8'h08, d);
    `CHK("width reset", 32'h32, d);
    for (int m = 0; m < 4; m++)
    begin
      v = {$random(seed)} & 32'hfffffff0 | m;
      wr(8'h00, v);
      rd(8'h00, d);
      `CHK("ctrl mode", (m == 3) ? 0 : m, d);
    end
    v = $random(seed);
    wr(8'h10, v);
    wr(8'h0c, v);
    rd(8'h10, d);
    `CHK("unmapped read", 0, d);
    rd(8'h0c, d);
    `CHK("status", 0, d);
    done("registers");
    for (int k = 0; k < 4; k++)
    begin
      m_code = {$random(seed)} % 128;
      wr(8'h00, 32'h4);
      wr(8'h04, {$random(seed)} & 32'hffffff80 | m_code);
      cyc(2);
      `CHK("code enables", m_code[6:0] ^ 7'h7f, code_oe);
      `CHK("code values", 0, code_out);
      `CHK("auto-on enable", 1, auto_on_oe);
      `CHK("auto-on value", 0, auto_on_out);
    end
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(8'h04, ~m_code);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(8'h04, d);
    `CHK("frozen write", m_code, d);
    done("pins");
    wr(8'h00, 32'h5);
    for (int k = 0; k < 4; k++)
    begin
      m_width = (k < 2) ? k : {$random(seed)} % 20 + 2;
      weff = (m_width == 0) ? 1 : m_width;
      wr(8'h08, m_width);
      wait_strobes(2);
      cyc(weff + 3);
      `CHK("strobe width", weff, last_width);
      `CHK("strobe gap", IVL, last_gap);
      `CHK("printed code", m_code, last_code);
    end
    done("repeat");
    for (int m = 0; m < 4; m += 3)
    begin
      wr(8'h00, 4 | m);
      cyc(IVL);
      c0 = strobe_cnt;
      cyc(2 * IVL + 50);
      `CHK("no strobes when off", c0, strobe_cnt);
    end
    done("off");
    wr(8'h00, 32'h6);
    cyc(IVL);
    for (int k = 0; k < 3; k++)
    begin
      c0 = strobe_cnt;
      @(posedge sys_clk);
      btn <= 1'b1;
      cyc(DBC * 4 + 20);
      `CHK("no strobe on press", c0, strobe_cnt);
      @(posedge sys_clk);
      btn <= 1'b0;
      cyc(DBC + 30 + weff);
      `CHK("one strobe on release", c0 + 1, strobe_cnt);
      cyc(2 * IVL);
      `CHK("no further strobe", c0 + 1, strobe_cnt);
      rd(8'h0c, d);
      `CHK("arm cleared", 0, d[2]);
    end
    done("manual");
    m_pd = 0;
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h00, (k == 0) ? 32'h4 : 32'hc);
      n = {$random(seed)} % 5 + 1;
      for (int p = 0; p < n; p++)
      begin
        @(posedge sys_clk);
        probe <= 1'b1;
        cyc({$random(seed)} % 4 + 5);
        @(posedge sys_clk);
        probe <= 1'b0;
        cyc(6);
        m_pd = (k == 0) ? m_pd : m_pd ^ 1;
      end
      cyc(12);
      `CHK("meter after pulses", m_pd, meter_out);
      cyc(50);
      `CHK("meter idle", m_pd, meter_out);
      rd(8'h0c, d);
      `CHK("detect toggle", m_pd, d[0]);
    end
    done("pulse detect");
    summarize();
  end
endmodule : tb_top
